// ===== verilog/imc_top.sv
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
module imc_top
  import imc_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int CHANNELS = 8,
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int PULSE_CYCLES = PULSE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link pins
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic mosi_pin,
  // Converter side
  input wire logic [CHANNELS-1:0] ch_enable,
  input wire logic [CHANNELS-1:0] ch_new_data,
  input wire logic data_read,
  input wire logic sample_valid,
  input wire logic [23:0] adc_result,
  input wire logic [15:0] regmap_crc,
  output logic [31:0] data_word,
  output logic data_word_valid,
  output logic crc_type_sel,
  output logic frame_active,
  // Ready pin
  output logic conversion_ready_pin_o,
  output logic conversion_ready_pin_oe,
  // Interrupt
  output logic irq
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_s1_q, rst_n;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic [ADDR_W-3:0] word_idx;
  logic hit_status, hit_mode, hit_istat, hit_imask, mapped;
  logic setup, wr_acc;
  assign word_idx = paddr[ADDR_W-1:2];
  assign hit_status = (word_idx == (ADDR_W-2)'(STATUS_IDX));
  assign hit_mode = (word_idx == (ADDR_W-2)'(MODE_IDX));
  assign hit_istat = (word_idx == (ADDR_W-2)'(INT_STAT_IDX));
  assign hit_imask = (word_idx == (ADDR_W-2)'(INT_MASK_IDX));
  assign mapped = hit_status | hit_mode | hit_istat | hit_imask;
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite & mapped;
  // Zero wait states; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ----------------------------------------
  // Mode register
  // ----------------------------------------
  imc_mode_t mode_q;
  imc_mode_t mode_wr;
  assign mode_wr = imc_mode_t'(pwdata[15:0]);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= imc_mode_t'(MODE_RST);
    end else if (wr_acc && hit_mode) begin
      mode_q.reg_crc_en <= mode_wr.reg_crc_en;
      mode_q.rx_crc_en <= mode_wr.rx_crc_en;
      mode_q.crc_type <= mode_wr.crc_type;
      mode_q.word_size_select <= mode_wr.word_size_select;
      // Reserved field is kept as written; host keeps it zero
      mode_q.rsvd_lo <= mode_wr.rsvd_lo;
      mode_q.timeout_en <= mode_wr.timeout_en;
      mode_q.ready_source_select <= mode_wr.ready_source_select;
      mode_q.ready_idle_float <= mode_wr.ready_idle_float;
      mode_q.ready_pulse_format <= mode_wr.ready_pulse_format;
    end
  end
  assign crc_type_sel = mode_q.crc_type;

  // ----------------------------------------
  // Reset-occurred flag
  // ----------------------------------------
  logic reset_flag_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_flag_q <= 1'b1;
    end else if (wr_acc && hit_mode && !mode_wr.reset_flag) begin
      reset_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Serial frame receiver
  // ----------------------------------------
  logic crc_fail, timeout_evt;
  imc_frame_rx #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
  ) u_rx (
    .clk(clk),
    .rst_n(rst_n),
    .sclk_pin(sclk_pin),
    .cs_n_pin(cs_n_pin),
    .mosi_pin(mosi_pin),
    .rx_crc_en(mode_q.rx_crc_en),
    .crc_type(mode_q.crc_type),
    .timeout_en(mode_q.timeout_en),
    .crc_fail(crc_fail),
    .timeout_evt(timeout_evt),
    .frame_active(frame_active)
  );

  // ----------------------------------------
  // Status flags, cleared by reading status
  // ----------------------------------------
  logic crc_err_q, regmap_chg_q;
  logic [15:0] regmap_prev_q;
  logic regmap_evt, status_rd;
  // Cleared at the edge that captures them, so no event slips between
  assign status_rd = setup & ~pwrite & hit_status;
  assign regmap_evt = mode_q.reg_crc_en & (regmap_crc != regmap_prev_q);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regmap_prev_q <= 16'h0;
    end else begin
      regmap_prev_q <= regmap_crc;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_err_q <= 1'b0;
    end else if (crc_fail) begin
      crc_err_q <= 1'b1;
    end else if (status_rd) begin
      crc_err_q <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regmap_chg_q <= 1'b0;
    end else if (regmap_evt) begin
      regmap_chg_q <= 1'b1;
    end else if (status_rd) begin
      regmap_chg_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Per-channel data available
  // ----------------------------------------
  logic [CHANNELS-1:0] avail_q;
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          avail_q[gi] <= 1'b0;
        end else if (ch_new_data[gi]) begin
          avail_q[gi] <= 1'b1;
        end else if (data_read) begin
          avail_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Ready source selection
  // ----------------------------------------
  logic [CHANNELS-1:0] en_avail;
  logic lead_q, src_lag, src_or, src, src_prev_q;
  assign en_avail = avail_q & ch_enable;
  assign src_lag = (|ch_enable) & (&(avail_q | ~ch_enable));
  assign src_or = |en_avail;
  // First enabled channel to report since the last read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lead_q <= 1'b0;
    end else if (|(ch_new_data & ch_enable)) begin
      lead_q <= 1'b1;
    end else if (data_read) begin
      lead_q <= 1'b0;
    end
  end
  always_comb begin
    case (mode_q.ready_source_select)
      SRC_LAG: src = src_lag;
      SRC_OR: src = src_or;
      default: src = lead_q;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src;
    end
  end

  // ----------------------------------------
  // Ready pin driver
  // ----------------------------------------
  imc_rdy_state_t rdy_q, rdy_d;
  logic [15:0] pulse_cnt_q;
  always_comb begin
    rdy_d = rdy_q;
    case (rdy_q)
      RD_IDLE: begin
        if (src && !src_prev_q) begin
          rdy_d = mode_q.ready_pulse_format ? RD_PULSE : RD_LEVEL;
        end
      end
      RD_LEVEL: begin
        if (!src) begin
          rdy_d = RD_IDLE;
        end
      end
      RD_PULSE: begin
        // Count is already one in the first low cycle
        if (pulse_cnt_q >= 16'(PULSE_CYCLES)) begin
          rdy_d = src ? RD_WAIT : RD_IDLE;
        end
      end
      RD_WAIT: begin
        if (!src) begin
          rdy_d = RD_IDLE;
        end
      end
      default: rdy_d = RD_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_q <= RD_IDLE;
      pulse_cnt_q <= 16'h0;
    end else begin
      rdy_q <= rdy_d;
      pulse_cnt_q <= (rdy_d == RD_PULSE) ? pulse_cnt_q + 16'h1 : 16'h0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conversion_ready_pin_o <= 1'b1;
      conversion_ready_pin_oe <= 1'b1;
    end else if (rdy_d == RD_LEVEL || rdy_d == RD_PULSE) begin
      conversion_ready_pin_o <= 1'b0;
      conversion_ready_pin_oe <= 1'b1;
    end else begin
      conversion_ready_pin_o <= 1'b1;
      conversion_ready_pin_oe <= ~mode_q.ready_idle_float;
    end
  end

  // ----------------------------------------
  // Output word formatting
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_word <= 32'h0;
      data_word_valid <= 1'b0;
    end else begin
      data_word_valid <= sample_valid;
      if (sample_valid) begin
        case (mode_q.word_size_select)
          WLEN_16: data_word <= {16'h0, adc_result[23:8]};
          WLEN_24: data_word <= {8'h0, adc_result};
          WLEN_32Z: data_word <= {adc_result, 8'h0};
          WLEN_32S: data_word <= {{8{adc_result[23]}}, adc_result};
          default: data_word <= {8'h0, adc_result};
        endcase
      end
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  logic [INT_W-1:0] int_stat_q, int_mask_q, int_evt;
  always_comb begin
    int_evt = '0;
    int_evt[INT_CRC_ERR] = crc_fail;
    int_evt[INT_REGMAP] = regmap_evt;
    int_evt[INT_TIMEOUT] = timeout_evt;
    int_evt[INT_READY] = |(ch_new_data & ch_enable);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_q <= '0;
    end else begin
      // A new event outweighs a clear in the same cycle
      int_stat_q <= int_evt | (int_stat_q &
        ~((wr_acc && hit_istat) ? pwdata[INT_W-1:0] : '0));
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_mask_q <= '0;
    end else if (wr_acc && hit_imask) begin
      int_mask_q <= pwdata[INT_W-1:0];
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat_q & int_mask_q);
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  imc_status_t status;
  imc_mode_t mode_rd;
  always_comb begin
    status = '0;
    status.regmap_changed = regmap_chg_q;
    status.crc_err = crc_err_q;
    status.crc_type = mode_q.crc_type;
    status.reset_flag = reset_flag_q;
    status.word_size_select = mode_q.word_size_select;
    status.ready = 8'(en_avail);
    mode_rd = mode_q;
    mode_rd.rsvd_hi = 2'h0;
    mode_rd.reset_flag = reset_flag_q;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (setup) begin
      prdata <= 32'h0;
      if (hit_status) begin
        prdata[15:0] <= status;
      end
      if (hit_mode) begin
        prdata[15:0] <= mode_rd;
      end
      if (hit_istat) begin
        prdata[INT_W-1:0] <= int_stat_q;
      end
      if (hit_imask) begin
        prdata[INT_W-1:0] <= int_mask_q;
      end
    end
  end

endmodule

// ===== verilog/imc_pkg.sv
package imc_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int TIMEOUT_NS = 20000;
  localparam int PULSE_NS = 100;
  // Longest time rounds down, least time rounds up
  localparam int TIMEOUT_CYC = TIMEOUT_NS * CLK_MHZ / 1000;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------
  // Register indices (byte address is four times)
  // ----------------------------------------
  localparam logic [7:0] STATUS_IDX = 8'h01;
  localparam logic [7:0] MODE_IDX = 8'h02;
  localparam logic [7:0] INT_STAT_IDX = 8'h08;
  localparam logic [7:0] INT_MASK_IDX = 8'h09;
  localparam logic [15:0] MODE_RST = 16'h0510;

  // ----------------------------------------
  // Interrupt bits
  // ----------------------------------------
  localparam int INT_W = 4;
  localparam int INT_CRC_ERR = 0;
  localparam int INT_REGMAP = 1;
  localparam int INT_TIMEOUT = 2;
  localparam int INT_READY = 3;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  localparam logic [1:0] WLEN_16 = 2'h0;
  localparam logic [1:0] WLEN_24 = 2'h1;
  localparam logic [1:0] WLEN_32Z = 2'h2;
  localparam logic [1:0] WLEN_32S = 2'h3;
  localparam logic [1:0] SRC_LAG = 2'h0;
  localparam logic [1:0] SRC_OR = 2'h1;
  localparam logic [15:0] POLY_CCITT = 16'h1021;
  localparam logic [15:0] POLY_ANSI = 16'h8005;
  localparam logic [15:0] CRC_SEED = 16'hFFFF;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic reg_crc_en;
    logic rx_crc_en;
    logic crc_type;
    logic reset_flag;
    logic [1:0] word_size_select;
    logic [2:0] rsvd_lo;
    logic timeout_en;
    logic [1:0] ready_source_select;
    logic ready_idle_float;
    logic ready_pulse_format;
  } imc_mode_t;

  typedef struct packed {
    logic lock;
    logic resync;
    logic regmap_changed;
    logic crc_err;
    logic crc_type;
    logic reset_flag;
    logic [1:0] word_size_select;
    logic [7:0] ready;
  } imc_status_t;

  typedef enum logic [1:0] {RD_IDLE, RD_LEVEL, RD_PULSE, RD_WAIT} imc_rdy_state_t;
  typedef enum logic {FR_IDLE, FR_ACTIVE} imc_frame_state_t;

endpackage

// ===== verilog/imc_frame_rx.sv
`timescale 1ns/1ps
module imc_frame_rx
  import imc_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial pins
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic mosi_pin,
  // Settings
  input wire logic rx_crc_en,
  input wire logic crc_type,
  input wire logic timeout_en,
  // Events
  output logic crc_fail,
  output logic timeout_evt,
  output logic frame_active
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] s1_q, s2_q;
  logic sclk_prev_q, cs_prev_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 3'h7;
      s2_q <= 3'h7;
      sclk_prev_q <= 1'b1;
      cs_prev_q <= 1'b1;
    end else begin
      s1_q <= {sclk_pin, cs_n_pin, mosi_pin};
      s2_q <= s1_q;
      sclk_prev_q <= s2_q[2];
      cs_prev_q <= s2_q[1];
    end
  end

  logic sclk_rise, cs_fall, cs_rise;
  assign sclk_rise = s2_q[2] & ~sclk_prev_q;
  assign cs_fall = ~s2_q[1] & cs_prev_q;
  assign cs_rise = s2_q[1] & ~cs_prev_q;

  // ----------------------------------------
  // Frame state, CRC and timeout
  // ----------------------------------------
  imc_frame_state_t state_q;
  logic [15:0] crc_q;
  logic [31:0] idle_cnt_q;
  logic [15:0] poly;
  logic fb;
  assign poly = crc_type ? POLY_ANSI : POLY_CCITT;
  assign fb = crc_q[15] ^ s2_q[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= FR_IDLE;
      crc_q <= CRC_SEED;
      idle_cnt_q <= 32'h0;
      crc_fail <= 1'b0;
      timeout_evt <= 1'b0;
    end else begin
      crc_fail <= 1'b0;
      timeout_evt <= 1'b0;
      case (state_q)
        FR_IDLE: begin
          idle_cnt_q <= 32'h0;
          if (cs_fall) begin
            state_q <= FR_ACTIVE;
            crc_q <= CRC_SEED;
          end
        end
        FR_ACTIVE: begin
          if (cs_rise) begin
            state_q <= FR_IDLE;
            crc_fail <= rx_crc_en & (crc_q != 16'h0);
          end else if (timeout_en && idle_cnt_q >= 32'(TIMEOUT_CYCLES - 1)) begin
            // Stalled frame is dropped, never checked
            state_q <= FR_IDLE;
            timeout_evt <= 1'b1;
          end else if (sclk_rise) begin
            idle_cnt_q <= 32'h0;
            crc_q <= {crc_q[14:0], 1'b0} ^ (fb ? poly : 16'h0);
          end else begin
            idle_cnt_q <= idle_cnt_q + 32'h1;
          end
        end
        default: state_q <= FR_IDLE;
      endcase
    end
  end

  assign frame_active = (state_q == FR_ACTIVE);

endmodule

// ===== tb/imc_host_model.sv
`timescale 1ns/1ps
module imc_host_model
  import imc_pkg::*;
(
  // Serial pins
  output logic sclk_pin,
  output logic cs_n_pin,
  output logic mosi_pin
);
  // Clock stands low outside frames
  initial begin
    sclk_pin = 1'b0;
    cs_n_pin = 1'b1;
    mosi_pin = 1'b0;
  end
  task automatic send(input logic [15:0] d, input logic ansi, input logic bad);
    logic [15:0] c;
    logic [31:0] f;
    c = CRC_SEED;
    for (int i = 15; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? (ansi ? POLY_ANSI : POLY_CCITT) : 16'h0000);
    end
    // Appended CRC leaves a zero residue unless spoiled on purpose
    f = {d, c ^ {15'h0000, bad}};
    cs_n_pin = 1'b0;
    // Edge gaps stay well under the bench's stall limit
    #125;
    for (int i = 31; i >= 0; i--) begin
      mosi_pin = f[i];
      #62.5;
      sclk_pin = 1'b1;
      #62.5;
      sclk_pin = 1'b0;
    end
    #125;
    cs_n_pin = 1'b1;
    // Released line must not keep the last bit
    mosi_pin = ~mosi_pin;
  endtask
  task automatic open();
    cs_n_pin = 1'b0;
  endtask
  task automatic close();
    cs_n_pin = 1'b1;
  endtask
endmodule

// ===== tb/imc_chk.sv
`timescale 1ns/1ps
module imc_chk
  import imc_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int PULSE_CYCLES = PULSE_CYC
) (
  // Clock, reset, bus
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  // Converter side
  input wire logic sample_valid,
  input wire logic [23:0] adc_result,
  input wire logic data_read,
  input wire logic [31:0] data_word,
  input wire logic data_word_valid,
  input wire logic crc_type_sel,
  input wire logic conversion_ready_pin_o,
  input wire logic conversion_ready_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // Shadow of the mode word, low-time counter
  // ----------------------------------------
  logic [15:0] mode_q;
  int low_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= MODE_RST;
    end else if (psel && penable && pwrite && paddr[ADDR_W-1:2] == (ADDR_W-2)'(MODE_IDX)) begin
      mode_q <= pwdata[15:0];
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_q <= 0;
    end else begin
      low_q <= conversion_ready_pin_o ? 0 : low_q + 1;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  crc_sel_a: assert property (crc_type_sel == mode_q[11])
    else $error("crc type output differs from mode");
  word_valid_a: assert property (data_word_valid == $past(sample_valid))
    else $error("word valid not one cycle after sample");
  word_short_a: assert property (sample_valid && !mode_q[9] |=> data_word == (mode_q[8] ?
    {8'h00, $past(adc_result)} : {16'h0000, $past(adc_result[23:8])}))
    else $error("16 or 24 bit word wrong");
  pad_zero_a: assert property (sample_valid && mode_q[9:8] == 2'h2 |=>
    data_word == {$past(adc_result), 8'h00})
    else $error("zero padded word wrong");
  sign_ext_a: assert property (sample_valid && mode_q[9:8] == 2'h3 |=>
    data_word == {{8{$past(adc_result[23])}}, $past(adc_result)})
    else $error("sign extended word wrong");
  idle_drive_a: assert property (conversion_ready_pin_o && $stable(mode_q[1]) |->
    conversion_ready_pin_oe == !mode_q[1])
    else $error("idle ready pin drive wrong");
  pulse_len_a: assert property ($rose(conversion_ready_pin_o) && mode_q[0] |->
    low_q == PULSE_CYCLES)
    else $error("ready pulse length wrong");
  level_hold_a: assert property (!conversion_ready_pin_o && !mode_q[0] && !data_read
    && !$past(data_read) && !$past(data_read, 2) |=> !conversion_ready_pin_o && conversion_ready_pin_oe)
    else $error("ready level released early");
endmodule

bind imc_top imc_chk #(.ADDR_W(ADDR_W), .PULSE_CYCLES(PULSE_CYCLES)) u_chk (
  .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .sample_valid(sample_valid), .adc_result(adc_result),
  .data_read(data_read), .data_word(data_word), .data_word_valid(data_word_valid),
  .crc_type_sel(crc_type_sel), .conversion_ready_pin_o(conversion_ready_pin_o),
  .conversion_ready_pin_oe(conversion_ready_pin_oe)
);

// ===== tb/interface_mode_config_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("BAD %s exp %h got %h", n, e, g); \
  end \
end
module interface_mode_config_tb;
  import imc_pkg::*;
  localparam logic [11:0] A_ST = {2'h0, STATUS_IDX, 2'h0};
  localparam logic [11:0] A_MD = {2'h0, MODE_IDX, 2'h0};
  localparam logic [11:0] A_IS = {2'h0, INT_STAT_IDX, 2'h0};
  localparam logic [11:0] A_IM = {2'h0, INT_MASK_IDX, 2'h0};
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, ev, irq;
  logic sclk_pin, cs_n_pin, mosi_pin, data_read, sample_valid, dwv, fa, cts, rdy_o, rdy_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, dw, ew;
  logic [7:0] ch_new_data;
  logic [23:0] adc_result, r;
  logic [15:0] regmap_crc;
  int errors, cmp_count, cyc, n;
  imc_top #(.TIMEOUT_CYCLES(50), .PULSE_CYCLES(4)) dut (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .mosi_pin(mosi_pin), .ch_enable(8'h0F),
    .ch_new_data(ch_new_data), .data_read(data_read), .sample_valid(sample_valid),
    .adc_result(adc_result), .regmap_crc(regmap_crc), .data_word(dw), .data_word_valid(dwv),
    .crc_type_sel(cts), .frame_active(fa), .conversion_ready_pin_o(rdy_o),
    .conversion_ready_pin_oe(rdy_oe), .irq(irq)
  );
  imc_host_model host (.sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .mosi_pin(mosi_pin));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rv & m)
  endtask
  task automatic strobe(input logic [7:0] m, input logic dr);
    @(posedge clk);
    ch_new_data <= m;
    data_read <= dr;
    @(posedge clk);
    ch_new_data <= 8'h00;
    data_read <= 1'b0;
  endtask
  task automatic pin_chk(input logic o, input logic oe, input string nm);
    repeat (10) @(posedge clk);
    `CHK(nm, {o, oe}, {rdy_o, rdy_oe})
  endtask
  task automatic frame(input logic [15:0] d, input logic ansi, input logic bad,
                       input logic [31:0] e);
    host.send(d, ansi, bad);
    repeat (10) @(posedge clk);
    rd(A_ST, 32'h1000, e, "crc flag");
  endtask
  initial begin
    {arst_n, psel, penable, pwrite, data_read, sample_valid} = 6'h00;
    {paddr, pwdata, ch_new_data, adc_result} = '0;
    regmap_crc = 16'h1234;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(A_MD, 32'hFFFF, 32'h0510, "mode reset");
    rd(A_ST, 32'hFFFF, 32'h0500, "status reset");
    rd(12'h0FC, 32'hFFFF_FFFF, 32'h0, "unmapped");
    `CHK("unmapped err", 1'b1, ev)
    apb(1'b1, A_MD, 32'h3B1F);
    rd(A_MD, 32'hFFFF, 32'h3B1F, "mode rw");
    rd(A_ST, 32'h0F00, 32'h0B00, "status mirror");
    apb(1'b1, A_MD, 32'h0510);
    rd(A_MD, 32'hFFFF, 32'h0110, "flag stays clear");
    $display("test registers done");
    r = 24'h8A5C3E;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, A_MD, 32'h0010 | (32'(c) << 8));
      case (c)
        0: ew = {16'h0000, r[23:8]};
        1: ew = {8'h00, r};
        2: ew = {r, 8'h00};
        default: ew = {{8{r[23]}}, r};
      endcase
      @(posedge clk);
      sample_valid <= 1'b1;
      adc_result <= r;
      @(posedge clk);
      sample_valid <= 1'b0;
      @(posedge clk);
      `CHK("word valid", 1'b1, dwv)
      `CHK("word", ew, dw)
    end
    $display("test word format done");
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, A_MD, 32'h0110 | (32'(s) << 2));
      strobe(8'h11, 1'b0);
      pin_chk(s == 0, 1'b1, "pin first");
      strobe(8'h0E, 1'b0);
      pin_chk(1'b0, 1'b1, "pin low");
      strobe(8'h00, 1'b1);
      pin_chk(1'b1, 1'b1, "pin idle");
    end
    apb(1'b1, A_MD, 32'h0117);
    pin_chk(1'b1, 1'b0, "pin float");
    apb(1'b1, A_IS, 32'hF);
    strobe(8'h01, 1'b0);
    n = 0;
    while (rdy_o !== 1'b0 && n < 10) begin
      n++;
      @(posedge clk);
    end
    `CHK("pulse drive", 2'b01, {rdy_o, rdy_oe})
    pin_chk(1'b1, 1'b0, "pulse end");
    `CHK("irq masked", 1'b0, irq)
    rd(A_IS, 32'h8, 32'h8, "int new data");
    apb(1'b1, A_IM, 32'h8);
    repeat (3) @(posedge clk);
    `CHK("irq on", 1'b1, irq)
    apb(1'b1, A_IS, 32'h8);
    repeat (3) @(posedge clk);
    `CHK("irq off", 1'b0, irq)
    apb(1'b1, A_IM, 32'h0);
    strobe(8'h00, 1'b1);
    $display("test ready pin done");
    apb(1'b1, A_MD, 32'h1110);
    frame(16'hA55A, 1'b0, 1'b0, 32'h0);
    frame(16'hA55A, 1'b0, 1'b1, 32'h1000);
    rd(A_IS, 32'h1, 32'h1, "crc int");
    apb(1'b1, A_MD, 32'h1910);
    frame(16'h3C96, 1'b1, 1'b0, 32'h0);
    frame(16'h3C96, 1'b0, 1'b0, 32'h1000);
    apb(1'b1, A_MD, 32'h0110);
    frame(16'hA55A, 1'b0, 1'b1, 32'h0);
    $display("test frame crc done");
    apb(1'b1, A_IS, 32'hF);
    host.open();
    repeat (100) @(posedge clk);
    `CHK("timeout close", 1'b0, fa)
    rd(A_IS, 32'h4, 32'h4, "timeout int");
    host.close();
    apb(1'b1, A_MD, 32'h0100);
    apb(1'b1, A_IS, 32'hF);
    host.open();
    repeat (100) @(posedge clk);
    `CHK("no timeout", 1'b1, fa)
    host.close();
    rd(A_IS, 32'h4, 32'h0, "no timeout int");
    $display("test timeout done");
    @(posedge clk);
    regmap_crc <= 16'h4321;
    repeat (5) @(posedge clk);
    rd(A_IS, 32'h2, 32'h0, "regmap off");
    apb(1'b1, A_MD, 32'h2110);
    repeat (5) @(posedge clk);
    apb(1'b0, A_ST, 32'h0);
    apb(1'b1, A_IS, 32'hF);
    @(posedge clk);
    regmap_crc <= 16'h1111;
    repeat (5) @(posedge clk);
    rd(A_ST, 32'h2000, 32'h2000, "regmap flag");
    rd(A_ST, 32'h2000, 32'h0, "regmap quiet");
    rd(A_IS, 32'h2, 32'h2, "regmap int");
    $display("test regmap done");
    report_and_stop();
  end
endmodule
